// >>> pkg/tmr_pkg.sv
// Package for the capture timer: register map, fields, reset values.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package tmr_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  // Register byte addresses.
  localparam logic [7:0]  CTL0_ADDR     = 8'h00;
  localparam logic [7:0]  CTL1_ADDR     = 8'h04;
  localparam logic [7:0]  CTL2_ADDR     = 8'h08;
  localparam logic [7:0]  CNT_HI_ADDR   = 8'h0C;
  localparam logic [7:0]  CNT_LO_ADDR   = 8'h10;
  localparam logic [7:0]  RLD_HI_ADDR   = 8'h14;
  localparam logic [7:0]  RLD_LO_ADDR   = 8'h18;
  localparam logic [7:0]  CAP_HI_ADDR   = 8'h1C;
  localparam logic [7:0]  CAP_LO_ADDR   = 8'h20;
  localparam logic [7:0]  NF_ADDR       = 8'h24;
  // Control 0 fields.
  localparam int          CTL0_CAUSE    = 7;
  localparam int          CTL0_IRQ      = 0;
  localparam int          IRQCFG_LSB    = 5;
  // Control 1 fields.
  localparam int          CTL1_EN       = 7;
  localparam int          CTL1_POL      = 6;
  // Noise filter fields.
  localparam int          NF_EN         = 7;
  localparam int          NF_SAT        = 3;
  localparam int          NF_WLSB       = 4;
  // Reset values and filter width limits.
  localparam logic [15:0] CNT_INIT      = 16'h0001;
  localparam logic [15:0] RLD_RESET     = 16'hFFFF;
  localparam logic [2:0]  NF_WSEL_RESET = 3'h0;
  localparam int          NF_MIN_W      = 4;
  localparam int          NF_MAX_W      = 11;
endpackage : tmr_pkg

// >>> hdl/capture_timer.sv
// Capture timer with coherent count readout and input noise filter.
// Assumes an APB master on clock_in and an asynchronous timer input pin.
// Functional notes
// - On selected input edge copy counter into capture registers.
// - Counter advances each timer clock up to the 16-bit reload value.
// - Polarity bit chooses rising or falling capture edge.
// - Capture raises interrupt; counter keeps running, no reload.
// - Capture sets the capture cause flag.
// - Reaching reload raises interrupt and counting continues.
// - Reload interrupt clears the capture cause flag.
// - Count may be read while enabled without disturbing timer.
// - Enabled high-byte read latches low byte into holding register.
// - Low-byte read after high-byte read returns holding register.
// - Disabled low-byte read returns live counter.
// - Timer output toggles at every reload.
// - Input synchronised to timer clock before sampling.
// - Filter enable 0 bypasses filter, 1 inserts it.
// - Filter counter width selectable from 4 to 11 bits.
// - Filter output switches only when counter saturates.
// - Active-low saturated output flags noise presence.
// - Filter keeps running in deepest sleep mode.
// - PWM duty and period follow reload, compare and prescale; this block has no compare or prescale and leaves them to software.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
module capture_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       sys_rst_in,
  // APB slave
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [tmr_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [tmr_pkg::DATA_W-1:0] pwdata_in,
  output logic      [tmr_pkg::DATA_W-1:0] prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  // Timer pins and status
  input  wire logic                       timer_in,
  output logic                            timer_out,
  output logic                            timer_irq_out,
  output logic                            filter_saturated_n_out
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [1:0]       sync;
    logic             in_prev;
    logic [10:0]      nf_cnt;
    logic             nf_out;
    logic             nf_sat_n;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] capture_value_regs;
    logic [7:0]       hold;
    logic             enable;
    logic             input_polarity_select;
    logic [1:0]       timer_irq_config;
    logic             capture_cause_flag;
    logic             irq_pend;
    logic             filter_enable;
    logic [2:0]       filter_width_select;
    logic             tout;
    logic             irq;
    logic [31:0]      rdata;
    logic             ready;
    logic             slverr;
  } state_t;

  state_t st;
  state_t next_st;

  // Top count of the filter counter for the selected width.
  function automatic logic [10:0] nf_top(input logic [2:0] wsel);
    nf_top = 11'((32'h1 << (NF_MIN_W + int'(wsel))) - 1);
  endfunction : nf_top

  logic             access;
  logic             wr;
  logic             rd;
  logic             in_s;
  logic             edge_hit;
  logic             reload_hit;
  logic [10:0]      top;

  always_comb begin
    next_st     = st;
    access      = psel_in && penable_in && !st.ready;
    wr          = access && pwrite_in;
    rd          = access && !pwrite_in;
    top         = nf_top(st.filter_width_select);
    // The filter runs off clock_in alone, so it needs no enable and keeps
    // working when the rest of the chip sleeps.
    next_st.sync = {st.sync[0], timer_in};
    if (st.sync[1]) begin
      // A narrower width chosen mid-run must not let the counter run on.
      if (st.nf_cnt < top) begin
        next_st.nf_cnt = st.nf_cnt + 11'h001;
      end
    end else if (st.nf_cnt != 11'h000) begin
      next_st.nf_cnt = st.nf_cnt - 11'h001;
    end
    if (st.nf_cnt >= top) begin
      next_st.nf_out = 1'b1;
    end else if (st.nf_cnt == 11'h000) begin
      next_st.nf_out = 1'b0;
    end
    // Low while the counter sits at either rail; high means noise.
    next_st.nf_sat_n = !(st.nf_cnt >= top || st.nf_cnt == 11'h000);
    in_s = st.filter_enable ? st.nf_out : st.sync[1];
    next_st.in_prev = in_s;
    edge_hit = st.input_polarity_select ? (!in_s && st.in_prev)
                                        : (in_s && !st.in_prev);
    reload_hit = st.enable && (st.count == st.reload);
    next_st.irq_pend = 1'b0;
    if (st.enable) begin
      if (reload_hit) begin
        next_st.count              = CNT_INIT;
        next_st.tout               = !st.tout;
        next_st.irq_pend           = 1'b1;
        next_st.capture_cause_flag = 1'b0;
      end else begin
        next_st.count = st.count + 16'h0001;
      end
      // Capture wins the cause flag over a same-cycle reload.
      if (edge_hit) begin
        next_st.capture_value_regs = st.count;
        next_st.irq_pend           = 1'b1;
        next_st.capture_cause_flag = 1'b1;
      end
    end
    next_st.irq = st.irq_pend;
    // APB: one wait state, ready pulses for one cycle.
    next_st.ready  = access;
    next_st.slverr = 1'b0;
    next_st.rdata  = 32'h0000_0000;
    if (wr) begin
      unique case (paddr_in)
        CTL0_ADDR: begin
          next_st.timer_irq_config = pwdata_in[IRQCFG_LSB+1:IRQCFG_LSB];
        end
        CTL1_ADDR: begin
          next_st.enable                = pwdata_in[CTL1_EN];
          next_st.input_polarity_select = pwdata_in[CTL1_POL];
        end
        CTL2_ADDR: begin
        end
        CNT_HI_ADDR: next_st.count[15:8]  = pwdata_in[7:0];
        CNT_LO_ADDR: next_st.count[7:0]   = pwdata_in[7:0];
        RLD_HI_ADDR: next_st.reload[15:8] = pwdata_in[7:0];
        RLD_LO_ADDR: next_st.reload[7:0]  = pwdata_in[7:0];
        NF_ADDR: begin
          next_st.filter_enable       = pwdata_in[NF_EN];
          next_st.filter_width_select =
            pwdata_in[NF_WLSB+2:NF_WLSB];
        end
        default: next_st.slverr = 1'b1;
      endcase
    end else if (rd) begin
      unique case (paddr_in)
        CTL0_ADDR: begin
          next_st.rdata[CTL0_CAUSE]                  = st.capture_cause_flag;
          next_st.rdata[IRQCFG_LSB+1:IRQCFG_LSB]     = st.timer_irq_config;
          next_st.rdata[CTL0_IRQ]                    = st.irq;
        end
        CTL1_ADDR: begin
          next_st.rdata[CTL1_EN]  = st.enable;
          next_st.rdata[CTL1_POL] = st.input_polarity_select;
        end
        CTL2_ADDR: next_st.rdata = 32'h0000_0000;
        CNT_HI_ADDR: begin
          next_st.rdata[7:0] = st.count[15:8];
          if (st.enable) begin
            next_st.hold = st.count[7:0];
          end
        end
        CNT_LO_ADDR: begin
          next_st.rdata[7:0] = st.enable ? st.hold
                                         : st.count[7:0];
        end
        RLD_HI_ADDR: next_st.rdata[7:0] = st.reload[15:8];
        RLD_LO_ADDR: next_st.rdata[7:0] = st.reload[7:0];
        CAP_HI_ADDR: next_st.rdata[7:0] = st.capture_value_regs[15:8];
        CAP_LO_ADDR: next_st.rdata[7:0] = st.capture_value_regs[7:0];
        NF_ADDR: begin
          next_st.rdata[NF_EN]                   = st.filter_enable;
          next_st.rdata[NF_WLSB+2:NF_WLSB]       = st.filter_width_select;
          next_st.rdata[NF_SAT]                  = st.nf_sat_n;
        end
        default: next_st.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st                     <= '0;
      st.reload              <= RLD_RESET;
      st.count               <= CNT_INIT;
      st.filter_width_select <= NF_WSEL_RESET;
      st.nf_sat_n            <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_out             = st.rdata;
  assign pready_out             = st.ready;
  assign pslverr_out            = st.slverr;
  assign timer_out              = st.tout;
  assign timer_irq_out          = st.irq;
  assign filter_saturated_n_out = st.nf_sat_n;

  // Duty and period follow from reload, compare and prescale in software;
  // this block exposes only the reload, count and captured values.

  a_capture_copy: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st.enable && edge_hit |=> st.capture_value_regs == $past(st.count))
    else $error("capture value mismatch");
  a_count_step: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st.enable && !reload_hit && !wr |=> st.count == $past(st.count) + 16'h0001)
    else $error("counter did not advance");
  a_reload_restart: assert property (@(posedge clock_in)
    disable iff (sys_rst_in) reload_hit && !wr |=> st.count == CNT_INIT)
    else $error("counter did not restart");
  a_cause_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st.enable && edge_hit |=> st.capture_cause_flag ##1 timer_irq_out)
    else $error("capture cause or irq missing");
  a_reload_irq: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    reload_hit && !edge_hit |=> !st.capture_cause_flag && $changed(st.tout)
    ##1 timer_irq_out)
    else $error("reload irq or toggle missing");
  a_hold_latch: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd && paddr_in == CNT_HI_ADDR && st.enable |=> st.hold == $past(st.count[7:0]))
    else $error("holding register not loaded");
  a_live_low: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd && paddr_in == CNT_LO_ADDR && !st.enable |=>
    prdata_out[7:0] == $past(st.count[7:0]))
    else $error("live low byte wrong");
  a_hyst_out: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    st.nf_cnt != 11'h000 && st.nf_cnt < top |=> $stable(st.nf_out))
    else $error("filter switched before saturating");

  // Input path: synchroniser, bypass and the saturating filter.
  a_sync_stage: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    1'b1 |=> st.sync[1] == $past(st.sync[0]))
    else $error("synchroniser stage skipped");
  a_bypass_path: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !st.filter_enable |-> in_s == st.sync[1])
    else $error("bypass path wrong");
  a_filter_up: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.sync[1] && st.nf_cnt < top |=> st.nf_cnt == $past(st.nf_cnt) + 11'h001)
    else $error("filter did not count up");
  a_filter_down: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !st.sync[1] && st.nf_cnt != 11'h000 |=>
    st.nf_cnt == $past(st.nf_cnt) - 11'h001)
    else $error("filter did not count down");
  a_filter_rise: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.nf_cnt >= top |=> st.nf_out)
    else $error("filter output not high at top");
  a_filter_fall: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.nf_cnt == 11'h000 |=> !st.nf_out)
    else $error("filter output not low at zero");

  // The saturation flag is what software uses to judge the line quality.
  a_sat_low: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.nf_cnt == 11'h000 |=> !filter_saturated_n_out)
    else $error("saturation flag not low at zero");
  a_sat_top: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.nf_cnt >= top |=> !filter_saturated_n_out)
    else $error("saturation flag not low at top");
  a_sat_high: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.nf_cnt != 11'h000 && st.nf_cnt < top |=> filter_saturated_n_out)
    else $error("saturation flag not high mid-range");
  a_width_sel: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    wr && paddr_in == NF_ADDR |=>
    st.filter_width_select == $past(pwdata_in[NF_WLSB+2:NF_WLSB]))
    else $error("filter width not stored");

  // Bus side: one wait state, pulses of one cycle.
  a_ready_wait: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready not given after one wait");
  a_ready_pulse: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    pready_out |=> !pready_out)
    else $error("ready held too long");
  a_slverr_only: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    pslverr_out |-> pready_out)
    else $error("error without ready");
  a_rdata_idle: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data outside ready cycle");
  a_en_write: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    wr && paddr_in == CTL1_ADDR |=> st.enable == $past(pwdata_in[CTL1_EN]))
    else $error("enable bit not stored");

  // Counter, capture and readout.
  a_idle_count: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !st.enable && !wr |=> $stable(st.count))
    else $error("counter moved while disabled");
  a_reload_value: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    reload_hit |-> st.count == st.reload)
    else $error("reload hit off value");
  a_capture_runs: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.enable && edge_hit && !reload_hit && !wr |=>
    st.count == $past(st.count) + 16'h0001)
    else $error("capture disturbed counting");
  a_read_quiet: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    rd && st.enable && !reload_hit |=> st.count == $past(st.count) + 16'h0001)
    else $error("read disturbed counting");
  a_hold_stable: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !(rd && paddr_in == CNT_HI_ADDR && st.enable) |=> $stable(st.hold))
    else $error("holding register changed");
  a_low_hold: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    rd && paddr_in == CNT_LO_ADDR && st.enable |=>
    prdata_out[7:0] == $past(st.hold))
    else $error("low byte not from holding register");
  a_toggle_only: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !reload_hit |=> $stable(st.tout))
    else $error("output toggled without reload");
  a_cause_hold: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !(st.enable && edge_hit) && !reload_hit |=> $stable(st.capture_cause_flag))
    else $error("cause flag changed without event");
  a_cap_hold: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !(st.enable && edge_hit) |=> $stable(st.capture_value_regs))
    else $error("capture value changed without edge");
  a_pol_fall: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.input_polarity_select && edge_hit |-> !in_s)
    else $error("falling capture on wrong level");
  a_pol_rise: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !st.input_polarity_select && edge_hit |-> in_s)
    else $error("rising capture on wrong level");
  a_irq_delay: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    st.irq_pend |=> timer_irq_out)
    else $error("pending interrupt not raised");
  a_irq_source: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    timer_irq_out |-> $past(st.irq_pend))
    else $error("interrupt without event");
  c_capture: cover property (@(posedge clock_in) st.enable && edge_hit);
  c_hold_read: cover property (@(posedge clock_in) rd && st.enable);
  c_slverr: cover property (@(posedge clock_in) pslverr_out);
  c_reload: cover property (@(posedge clock_in) reload_hit);
  c_filtered: cover property (@(posedge clock_in) st.filter_enable && !st.nf_sat_n);
endmodule : capture_timer

// >>> verif/timer_pin_model.sv
// Far-side model of the timer input pin and the timer output pin.
// Assumes drive() is called just after a rising edge of clock_in.
`timescale 1ns/10ps
module timer_pin_model (
  // Clock and pins
  input  wire logic clock_in,
  input  wire logic tmr_pin_in,
  output logic      pin_level_out,
  output int        toggles_out
);
  logic last_pin = 1'b0;
  initial pin_level_out = 1'b0;
  initial toggles_out = 0;
  // Counts output toggles; the bench times reloads from this count.
  always @(posedge clock_in) begin
    if (tmr_pin_in !== last_pin) toggles_out <= toggles_out + 1;
    last_pin <= tmr_pin_in;
  end
  // Short holds model noise pulses, long holds model real edges.
  task automatic drive(input logic lvl, input int cycles);
    pin_level_out <= lvl;
    repeat (cycles) @(posedge clock_in);
  endtask : drive
endmodule : timer_pin_model

// >>> verif/timer_capture_readout_filter_bench.sv
// Self-checking bench for the capture timer: registers, capture, readout.
// Assumes the APB slave and the pin model answer as the hand-over says.
`timescale 1ns/10ps
module timer_capture_readout_filter_bench;
  import tmr_pkg::*;
  logic        clock_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, tin, tout, irq, sat_n, err;
  logic [15:0] v1, v2;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          irqs = 0;
  int          togs, c1, c2;
  always #2.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
  end
  capture_timer uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pwd), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .timer_in(tin), .timer_out(tout),
    .timer_irq_out(irq), .filter_saturated_n_out(sat_n));
  timer_pin_model pin (.clock_in(clock_in), .tmr_pin_in(tout),
    .pin_level_out(tin), .toggles_out(togs));
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock_in);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wait_tog(input int want, output int at);
    int n;
    for (n = 0; n < 300 && togs < want; n++) @(posedge clock_in);
    at = cyc;
    if (togs < want) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_tog
  task automatic sc_regs();
    apb(1'b0, CNT_LO_ADDR, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, RLD_HI_ADDR, 32'h0);
    check(rd, 32'hFF);
    apb(1'b0, NF_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h28, 32'h5A);
    check({31'h0, err}, 32'h1);
  endtask : sc_regs
  task automatic sc_capture();
    int b;
    apb(1'b1, CTL1_ADDR, 32'h0);
    apb(1'b1, CTL2_ADDR, 32'h0);
    apb(1'b1, CTL0_ADDR, 32'h0);
    apb(1'b1, CTL1_ADDR, 32'h80);
    b = irqs;
    pin.drive(1'b1, 30);
    check(irqs - b, 32'h1);
    apb(1'b0, CAP_HI_ADDR, 32'h0);
    v1[15:8] = rd[7:0];
    apb(1'b0, CAP_LO_ADDR, 32'h0);
    v1[7:0] = rd[7:0];
    check({31'h0, v1 >= 16'h2 && v1 <= 16'hA}, 32'h1);
    apb(1'b0, CTL0_ADDR, 32'h0);
    check({31'h0, rd[CTL0_CAUSE]}, 32'h1);
    apb(1'b0, CNT_HI_ADDR, 32'h0);
    apb(1'b0, CNT_LO_ADDR, 32'h0);
    check({31'h0, rd[7:0] > v1[7:0] + 8'h8}, 32'h1);
    b = irqs;
    pin.drive(1'b0, 30);
    apb(1'b1, CTL1_ADDR, 32'hC0);
    pin.drive(1'b1, 30);
    check(irqs - b, 32'h0);
    pin.drive(1'b0, 30);
    check(irqs - b, 32'h1);
  endtask : sc_capture
  task automatic sc_readout();
    apb(1'b0, CNT_HI_ADDR, 32'h0);
    c1 = cyc;
    v1[15:8] = rd[7:0];
    repeat (20) @(posedge clock_in);
    apb(1'b0, CNT_LO_ADDR, 32'h0);
    v1[7:0] = rd[7:0];
    apb(1'b0, CNT_HI_ADDR, 32'h0);
    c2 = cyc;
    v2[15:8] = rd[7:0];
    apb(1'b0, CNT_LO_ADDR, 32'h0);
    v2[7:0] = rd[7:0];
    check(v2 - v1, c2 - c1);
    apb(1'b1, CTL1_ADDR, 32'h0);
    apb(1'b1, CNT_HI_ADDR, 32'h12);
    apb(1'b1, CNT_LO_ADDR, 32'h34);
    apb(1'b0, CNT_HI_ADDR, 32'h0);
    apb(1'b0, CNT_LO_ADDR, 32'h0);
    check(rd, 32'h34);
  endtask : sc_readout
  task automatic sc_reload();
    int b;
    apb(1'b1, RLD_HI_ADDR, 32'h0);
    apb(1'b1, RLD_LO_ADDR, 32'h20);
    apb(1'b1, CNT_HI_ADDR, 32'h0);
    apb(1'b1, CNT_LO_ADDR, 32'h1);
    b = irqs;
    apb(1'b1, CTL1_ADDR, 32'h80);
    wait_tog(togs + 1, c1);
    wait_tog(togs + 1, c2);
    check(c2 - c1, 32'h20);
    repeat (4) @(posedge clock_in);
    check(irqs - b, 32'h2);
    apb(1'b0, CTL0_ADDR, 32'h0);
    check({31'h0, rd[CTL0_CAUSE]}, 32'h0);
  endtask : sc_reload
  task automatic sc_filter();
    int b;
    apb(1'b1, RLD_HI_ADDR, 32'hFF);
    apb(1'b1, RLD_LO_ADDR, 32'hFF);
    apb(1'b1, CTL1_ADDR, 32'h80);
    apb(1'b1, NF_ADDR, 32'h80);
    pin.drive(1'b0, 40);
    check({31'h0, sat_n}, 32'h0);
    b = irqs;
    pin.drive(1'b1, 6);
    pin.drive(1'b0, 40);
    check(irqs - b, 32'h0);
    pin.drive(1'b1, 60);
    check(irqs - b, 32'h1);
    apb(1'b1, NF_ADDR, 32'h90);
    pin.drive(1'b0, 80);
    b = irqs;
    pin.drive(1'b1, 20);
    pin.drive(1'b0, 80);
    check(irqs - b, 32'h0);
    apb(1'b1, NF_ADDR, 32'h0);
    pin.drive(1'b1, 4);
    pin.drive(1'b0, 20);
    check(irqs - b, 32'h1);
  endtask : sc_filter
  initial begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    sc_regs();
    sc_capture();
    sc_readout();
    sc_reload();
    sc_filter();
    stop_test();
  end
  initial begin
    repeat (50000) @(posedge clock_in);
    fail_count++;
    stop_test();
  end
endmodule : timer_capture_readout_filter_bench
